// ### core/spi_fram_pkg.sv
// Constants shared by the serial RAM device end, the host end and the link.
// Assumes nothing beyond a SystemVerilog compiler; compile first.
// Operation
// - Select high: standby, inputs ignored, output off
// - Host drops select before every command byte
// - Capture on rising clock, shift out falling
// - Clock zero to 15 MHz, stoppable
// - Pause low freezes operation, resumes afterwards
// - Pause low: clock edges ignored, select rising still ends the frame
// - Host changes pause only while clock low
// - Lock input low rejects status writes
// - Serial input sampled on rising edges only
// - Output driven only while returning read data
// - Array of 2048 byte locations
// - Command, then two address bytes
// - Top five address bits ignored, eleven used
// - Written byte stored at once, no busy
// - Modes 0,0 and 1,1 both accepted
// - Eight-bit units, most significant bit first
// - Six command codes decoded
// - One command per select assertion
package spi_fram_pkg;
  localparam int byte_w = 8;
  localparam int addr_w = 11;
  localparam int mem_depth = 2048;
  localparam logic [2:0] bit_last = 3'h7;
  localparam logic [7:0] set_write_latch_cmd = 8'h06;
  localparam logic [7:0] clear_write_latch_cmd = 8'h04;
  localparam logic [7:0] read_status_cmd = 8'h05;
  localparam logic [7:0] write_status_cmd = 8'h01;
  localparam logic [7:0] read_mem_cmd = 8'h03;
  localparam logic [7:0] write_mem_cmd = 8'h02;
  localparam int st_wpen_bit = 7;
  localparam int st_bp_hi = 3;
  localparam int st_bp_lo = 2;
  localparam int st_wel_bit = 1;
  localparam logic [7:0] nv_status_rst = 8'h00;
  localparam logic miso_idle = 1'b1;
  localparam longint sys_hz = 125_000_000;
  localparam longint sck_max_hz = 15_000_000;
  localparam int sck_half_cyc = int'((sys_hz + 2 * sck_max_hz - 1) / (2 * sck_max_hz));
endpackage : spi_fram_pkg

// ### core/spi_link_if.sv
// Serial link between the host end and the device end.
// Assumes spi_fram_pkg is compiled; the output line idles high when undriven.
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so;
  logic so_oe_n;
  logic miso;
  // Pulled up when the device lets go
  assign miso = so_oe_n ? spi_fram_pkg::miso_idle : so;
  modport dev (input sck, input cs_n, input si, input hold_n, input wp_n,
               output so, output so_oe_n);
  modport host (output sck, output cs_n, output si, output hold_n, output wp_n,
                input miso);
endinterface : spi_link_if
`default_nettype wire

// ### core/spi_fram_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module spi_fram_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == LAST) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_inc

  assign in_ready_out = count_r != FULL;
  assign out_valid_out = count_r != '0;
  assign out_data_out = mem_r[rd_ptr_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : spi_fram_fifo
`default_nettype wire

// ### core/spi_fram_device.sv
// Device end: byte-addressed nonvolatile RAM behind the serial link.
// Assumes the host makes the link clock; link logic runs on it alone.
`timescale 1ns/1ps
`default_nettype none
module spi_fram_device #(
  parameter int DEPTH = spi_fram_pkg::mem_depth
) (
  spi_link_if.dev link,
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  output logic write_latch_out,
  output logic byte_written_out
);
  localparam int AW = $clog2(DEPTH);

  typedef enum logic [4:0] {
    ph_op = 5'h01,
    ph_ah = 5'h02,
    ph_al = 5'h04,
    ph_data = 5'h08,
    ph_done = 5'h10
  } phase_e;

  // Link reset and lock synchronisers
  logic rst_s1_r;
  logic rst_s2_r;
  logic wp_s1_r;
  logic wp_s2_r;

  // Per-frame state, cleared by select high
  phase_e phase_r;
  phase_e phase_nxt;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] opcode_r;
  logic [7:0] addr_hi_r;

  // State kept across frames
  logic [AW-1:0] addr_r;
  logic [AW-1:0] addr_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic wel_r;
  logic wrote_r;
  logic wpen_r;
  logic [1:0] bp_r;
  logic wr_tgl_r;
  logic [7:0] mem [DEPTH];

  // Output side
  logic so_r;
  logic drv_r;

  // System clock side
  logic wl_s1_r;
  logic tg_s1_r;
  logic tg_s2_r;
  logic tg_s3_r;

  // Decode
  logic [7:0] rx_byte;
  logic [15:0] addr_field;
  logic [AW-1:0] addr_sel;
  logic [AW-1:0] addr_inc;
  logic [7:0] op_sel;
  logic [7:0] status_byte;
  logic byte_done;
  logic act;
  logic first_edge;
  logic op_end;
  logic cmd_rd;
  logic cmd_wr;
  logic cmd_rs;
  logic cmd_ws;
  logic cmd_set;
  logic cmd_clr;
  logic data_end;
  logic mem_wr_ok;
  logic st_wr_ok;
  logic tx_load;
  logic addr_load;
  logic out_phase;

  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
    next_addr = AW'(a + 1'b1);
  endfunction : next_addr

  assign rx_byte = {rx_sh_r[6:0], link.si};
  assign byte_done = bit_cnt_r == spi_fram_pkg::bit_last;
  assign act = ~link.cs_n & link.hold_n;
  assign first_edge = (phase_r == ph_op) && (bit_cnt_r == '0);
  assign op_end = byte_done && (phase_r == ph_op);
  assign data_end = byte_done && (phase_r == ph_data);
  assign op_sel = (phase_r == ph_op) ? rx_byte : opcode_r;
  assign cmd_rd = op_sel == spi_fram_pkg::read_mem_cmd;
  assign cmd_wr = op_sel == spi_fram_pkg::write_mem_cmd;
  assign cmd_rs = op_sel == spi_fram_pkg::read_status_cmd;
  assign cmd_ws = op_sel == spi_fram_pkg::write_status_cmd;
  assign cmd_set = op_sel == spi_fram_pkg::set_write_latch_cmd;
  assign cmd_clr = op_sel == spi_fram_pkg::clear_write_latch_cmd;
  assign addr_field = {addr_hi_r, rx_byte};
  assign addr_sel = addr_field[AW-1:0];
  assign addr_inc = next_addr(addr_r);
  assign status_byte = (8'(wpen_r) << spi_fram_pkg::st_wpen_bit)
                     | (8'(bp_r) << spi_fram_pkg::st_bp_lo)
                     | (8'(wel_r) << spi_fram_pkg::st_wel_bit);
  assign mem_wr_ok = act && data_end && cmd_wr && wel_r;
  assign st_wr_ok = act && data_end && cmd_ws && wel_r && wp_s2_r;
  assign tx_load = (op_end && cmd_rs) || (byte_done && phase_r == ph_al)
                 || (data_end && cmd_rd);
  assign tx_nxt = (phase_r == ph_op) ? status_byte
                : (phase_r == ph_al) ? mem[addr_sel] : mem[addr_inc];
  assign addr_load = (byte_done && phase_r == ph_al) || (data_end && (cmd_rd || cmd_wr));
  assign addr_nxt = (phase_r == ph_al) ? addr_sel : addr_inc;
  assign out_phase = (phase_r == ph_data) && (cmd_rd || cmd_rs);

  // Frame sequencer; a finished command ignores the rest of the frame
  always_comb begin
    phase_nxt = phase_r;
    if (byte_done) begin
      case (phase_r)
        ph_op: begin
          if (cmd_rd || cmd_wr) begin
            phase_nxt = ph_ah;
          end else if (cmd_rs || cmd_ws) begin
            phase_nxt = ph_data;
          end else begin
            phase_nxt = ph_done;
          end
        end
        ph_ah: phase_nxt = ph_al;
        ph_al: phase_nxt = ph_data;
        ph_data: phase_nxt = (cmd_rs || cmd_ws) ? ph_done : ph_data;
        ph_done: phase_nxt = ph_done;
        default: phase_nxt = ph_done;
      endcase
    end
  end

  // Reset released on link clock edges only
  always_ff @(posedge link.sck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  always_ff @(posedge link.sck) begin
    wp_s1_r <= link.wp_n;
    wp_s2_r <= wp_s1_r;
  end

  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      phase_r <= ph_op;
      bit_cnt_r <= '0;
      rx_sh_r <= '0;
      opcode_r <= '0;
      addr_hi_r <= '0;
    end else if (link.hold_n) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r <= rx_byte;
      phase_r <= phase_nxt;
      if (op_end) begin
        opcode_r <= rx_byte;
      end
      if (byte_done && phase_r == ph_ah) begin
        addr_hi_r <= rx_byte;
      end
    end
  end

  // Static logic: nothing times out while the clock stands still
  always_ff @(posedge link.sck or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      wel_r <= 1'b0;
      wrote_r <= 1'b0;
      wpen_r <= spi_fram_pkg::nv_status_rst[spi_fram_pkg::st_wpen_bit];
      bp_r <= spi_fram_pkg::nv_status_rst[spi_fram_pkg::st_bp_hi:spi_fram_pkg::st_bp_lo];
      tx_r <= '0;
      addr_r <= '0;
      wr_tgl_r <= 1'b0;
    end else if (act) begin
      if (first_edge && wrote_r) begin
        wel_r <= 1'b0;
        wrote_r <= 1'b0;
      end
      if (op_end && cmd_set) begin
        wel_r <= 1'b1;
      end
      if (op_end && cmd_clr) begin
        wel_r <= 1'b0;
      end
      if (mem_wr_ok || st_wr_ok) begin
        wrote_r <= 1'b1;
      end
      if (st_wr_ok) begin
        wpen_r <= rx_byte[spi_fram_pkg::st_wpen_bit];
        bp_r <= rx_byte[spi_fram_pkg::st_bp_hi:spi_fram_pkg::st_bp_lo];
      end
      if (mem_wr_ok) begin
        wr_tgl_r <= ~wr_tgl_r;
      end
      if (tx_load) begin
        tx_r <= tx_nxt;
      end
      if (addr_load) begin
        addr_r <= addr_nxt;
      end
    end
  end

  always_ff @(posedge link.sck) begin
    if (mem_wr_ok) begin
      mem[addr_r] <= rx_byte;
    end
  end

  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      so_r <= 1'b0;
      drv_r <= 1'b0;
    end else if (link.hold_n) begin
      so_r <= tx_r[~bit_cnt_r];
      drv_r <= out_phase;
    end
  end

  assign link.so = so_r;
  assign link.so_oe_n = ~(drv_r & link.hold_n);

  // Latch level and write events into the system clock
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wl_s1_r <= 1'b0;
      write_latch_out <= 1'b0;
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
      byte_written_out <= 1'b0;
    end else begin
      wl_s1_r <= wel_r;
      write_latch_out <= wl_s1_r;
      tg_s1_r <= wr_tgl_r;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
      byte_written_out <= tg_s2_r ^ tg_s3_r;
    end
  end
endmodule : spi_fram_device
`default_nettype wire

// ### core/spi_fram_host.sv
// Host end: shifts user bytes over the link in mode 0, returns what comes back.
// Assumes a system clock; the link clock is divided from it.
`timescale 1ns/1ps
`default_nettype none
module spi_fram_host #(
  parameter int HALF_CYC = spi_fram_pkg::sck_half_cyc
) (
  spi_link_if.host link,
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_ready_in,
  input wire logic hold_req_in,
  input wire logic wp_n_in,
  output logic busy_out
);
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] HALF_END = CW'(HALF_CYC - 1);

  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_low = 5'h02,
    st_high = 5'h04,
    st_wait = 5'h08,
    st_tail = 5'h10
  } state_e;

  state_e state_r;
  state_e state_nxt;
  logic [CW-1:0] cnt_r;
  logic [2:0] bit_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic [7:0] push_data_r;
  logic last_r;
  logic sck_r;
  logic cs_n_r;
  logic hold_n_r;
  logic wp_n_r;
  logic miso_s1_r;
  logic miso_s2_r;
  logic push_r;
  logic half_done;
  logic buf_ready;
  logic take;
  logic frozen;

  assign half_done = cnt_r == HALF_END;
  assign tx_ready_out = (state_r == st_idle || state_r == st_wait) && half_done
                      && buf_ready && hold_n_r;
  assign take = tx_ready_out && tx_valid_in;
  assign frozen = (state_r == st_low) && !hold_n_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_idle: state_nxt = take ? st_low : st_idle;
      st_wait: state_nxt = take ? st_low : st_wait;
      st_low: state_nxt = (half_done && hold_n_r) ? st_high : st_low;
      st_high: begin
        if (half_done) begin
          if (bit_r != spi_fram_pkg::bit_last) begin
            state_nxt = st_low;
          end else begin
            state_nxt = last_r ? st_tail : st_wait;
          end
        end
      end
      st_tail: state_nxt = half_done ? st_idle : st_tail;
      default: state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    miso_s1_r <= link.miso;
    miso_s2_r <= miso_s1_r;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_r <= st_idle;
      cnt_r <= '0;
      bit_r <= '0;
      tx_sh_r <= '0;
      rx_sh_r <= '0;
      push_data_r <= '0;
      last_r <= 1'b0;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      hold_n_r <= 1'b1;
      wp_n_r <= 1'b1;
      push_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wp_n_r <= wp_n_in;
      push_r <= 1'b0;
      if (state_nxt != state_r) begin
        cnt_r <= '0;
      end else if (!half_done && !frozen) begin
        cnt_r <= cnt_r + 1'b1;
      end
      if (state_r != st_high && state_nxt != st_high) begin
        hold_n_r <= ~hold_req_in;
      end
      if (take) begin
        tx_sh_r <= tx_data_in;
        last_r <= tx_last_in;
        bit_r <= '0;
        cs_n_r <= 1'b0;
      end
      if (state_r == st_low && state_nxt == st_high) begin
        sck_r <= 1'b1;
        rx_sh_r <= {rx_sh_r[6:0], miso_s2_r};
      end
      if (state_r == st_high && half_done) begin
        sck_r <= 1'b0;
        if (bit_r != spi_fram_pkg::bit_last) begin
          bit_r <= bit_r + 3'h1;
          tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end else begin
          push_r <= 1'b1;
          push_data_r <= rx_sh_r;
        end
      end
      if (state_r == st_tail && half_done) begin
        cs_n_r <= 1'b1;
      end
    end
  end

  spi_fram_fifo #(
    .WIDTH(spi_fram_pkg::byte_w),
    .DEPTH(2)
  ) u_rx_fifo (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push_r),
    .in_ready_out(buf_ready),
    .in_data_in(push_data_r),
    .out_valid_out(rx_valid_out),
    .out_ready_in(rx_ready_in),
    .out_data_out(rx_data_out)
  );

  assign link.sck = sck_r;
  assign link.cs_n = cs_n_r;
  assign link.si = tx_sh_r[7];
  assign link.hold_n = hold_n_r;
  assign link.wp_n = wp_n_r;
  assign busy_out = ~cs_n_r;
endmodule : spi_fram_host
`default_nettype wire

// ### tb/spi_fram_monitor.sv
// Checker: timing and framing properties of the serial link.
// Assumes instantiation beside the link interface, signals by name.
`timescale 1ns/1ps
`default_nettype none
module spi_fram_monitor #(
  parameter int HALF_CYC = spi_fram_pkg::sck_half_cyc
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic hold_n_in,
  input wire logic so_in,
  input wire logic so_oe_n_in,
  input wire logic miso_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] hi_cnt_r;
  logic [2:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  logic sck_d_r;
  logic sck_rise;
  logic byte_end;
  assign sck_rise = sck_in & ~sck_d_r;
  assign byte_end = sck_rise && (bit_cnt_r == 3'h7);
  // High phase length, rising edges and whole bytes within a frame
  always_ff @(posedge clk_sys_in) begin
    sck_d_r <= sck_in;
    hi_cnt_r <= sck_in ? hi_cnt_r + 8'h01 : 8'h00;
    bit_cnt_r <= cs_n_in ? 3'h0 : bit_cnt_r + {2'h0, sck_rise};
    if (cs_n_in) begin
      byte_cnt_r <= 2'h0;
    end else if (byte_end && byte_cnt_r != 2'h3) begin
      byte_cnt_r <= byte_cnt_r + 2'h1;
    end
  end
  a_idle_out_off: assert property (cs_n_in |-> so_oe_n_in)
    else $error("output enabled while deselected");
  a_hold_out_off: assert property (!hold_n_in |-> so_oe_n_in)
    else $error("output enabled during pause");
  a_released_pull_up: assert property (so_oe_n_in |-> miso_in)
    else $error("released data line not high");
  a_opcode_out_off: assert property ((byte_cnt_r == 2'h0) |-> so_oe_n_in)
    else $error("output enabled during command byte");
  a_so_on_fall: assert property ((!so_oe_n_in && $changed(so_in)) |-> $fell(sck_in))
    else $error("output changed away from a falling clock");
  a_si_sck_low: assert property ($changed(si_in) |-> !sck_in)
    else $error("input data changed while clock high");
  a_hold_sck_low: assert property ($changed(hold_n_in) |-> !sck_in)
    else $error("pause changed while clock high");
  a_high_phase_len: assert property ($fell(sck_in) |-> hi_cnt_r == 8'(HALF_CYC))
    else $error("clock high phase length wrong");
  a_whole_bytes: assert property ($rose(cs_n_in) |-> bit_cnt_r == 3'h0)
    else $error("frame ended inside a byte");
  a_sck_idle_low: assert property (cs_n_in |-> !sck_in)
    else $error("clock not idle low between frames");
endmodule : spi_fram_monitor
`default_nettype wire

// ### tb/test_spi_fram_slave_interface.sv
// Testbench: host end and device end joined by the link, user side driven.
// Assumes the core package, interface, fifo, host and device are compiled.
`timescale 1ns/1ps
`default_nettype none
module test_spi_fram_slave_interface;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b1;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_last = 1'b0;
  logic rx_ready = 1'b1;
  logic hold_req = 1'b0;
  logic wp_n = 1'b1;
  logic tx_ready, rx_valid, busy, write_latch, byte_written;
  logic [7:0] rx_data;
  logic [7:0] r;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_written = 0;
  int n0;
  spi_link_if link ();
  spi_fram_host spi_fram_host_i (.link(link), .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_last_in(tx_last),
    .tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .rx_ready_in(rx_ready), .hold_req_in(hold_req), .wp_n_in(wp_n), .busy_out(busy));
  spi_fram_device spi_fram_device_i (.link(link), .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .write_latch_out(write_latch), .byte_written_out(byte_written));
  spi_fram_monitor #(.HALF_CYC(spi_fram_pkg::sck_half_cyc)) spi_fram_monitor_i (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .sck_in(link.sck), .cs_n_in(link.cs_n), .si_in(link.si), .hold_n_in(link.hold_n),
    .so_in(link.so), .so_oe_n_in(link.so_oe_n), .miso_in(link.miso));
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (byte_written === 1'b1) n_written++;
  task automatic conclude;
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic send(input logic [7:0] d, input logic last);
    int i = 0;
    @(posedge clk_sys_in);
    tx_valid <= 1'b1;
    tx_data <= d;
    tx_last <= last;
    do begin
      @(posedge clk_sys_in);
      i++;
    end while (tx_ready !== 1'b1 && i < 4000);
    tx_valid <= 1'b0;
    if (tx_ready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask : send
  task automatic recv(output logic [7:0] v);
    int i = 0;
    do begin
      @(posedge clk_sys_in);
      i++;
    end while (rx_valid !== 1'b1 && i < 4000);
    v = rx_data;
    if (rx_valid !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask : recv
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] v);
    send(d, last);
    recv(v);
  endtask : xfer
  task automatic cmd(input logic [7:0] op);
    xfer(op, 1'b1, r);
  endtask : cmd
  task automatic status(input logic [7:0] exp);
    xfer(spi_fram_pkg::read_status_cmd, 1'b0, r);
    xfer(8'h00, 1'b1, r);
    chk("status", r, exp);
  endtask : status
  // Memory frame; optional pause in the middle of the first data byte
  task automatic mem(input logic [7:0] op, input logic [15:0] a, input int n,
                     input logic [7:0] d[3], input logic hp);
    int k;
    xfer(op, 1'b0, r);
    xfer(a[15:8], 1'b0, r);
    xfer(a[7:0], 1'b0, r);
    for (k = 0; k < n; k++) begin
      send(d[k], k == n - 1);
      if (hp && k == 0) begin
        repeat (20) @(posedge clk_sys_in);
        hold_req <= 1'b1;
        repeat (60) @(posedge clk_sys_in);
        hold_req <= 1'b0;
      end
      recv(r);
      if (op == spi_fram_pkg::read_mem_cmd) chk("mem", r, d[k]);
    end
  endtask : mem
  initial begin
    // Falling edge seeds the link side reset
    rst_n_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    status(8'h00);
    cmd(spi_fram_pkg::set_write_latch_cmd);
    repeat (8) @(posedge clk_sys_in);
    chk("latch", {7'h00, write_latch}, 8'h01);
    status(8'h02);
    cmd(spi_fram_pkg::clear_write_latch_cmd);
    repeat (8) @(posedge clk_sys_in);
    chk("latch clear", {7'h00, write_latch}, 8'h00);
    status(8'h00);
    cmd(spi_fram_pkg::set_write_latch_cmd);
    wp_n <= 1'b0;
    xfer(spi_fram_pkg::write_status_cmd, 1'b0, r);
    xfer(8'hFF, 1'b1, r);
    cmd(spi_fram_pkg::clear_write_latch_cmd);
    status(8'h00);
    wp_n <= 1'b1;
    cmd(spi_fram_pkg::set_write_latch_cmd);
    xfer(spi_fram_pkg::write_status_cmd, 1'b0, r);
    xfer(8'hFF, 1'b1, r);
    status(8'h8C);
    n0 = n_written;
    cmd(spi_fram_pkg::set_write_latch_cmd);
    mem(spi_fram_pkg::write_mem_cmd, 16'hF7FF, 3, '{8'hA1, 8'hB2, 8'hC3}, 1'b0);
    repeat (10) @(posedge clk_sys_in);
    chk("writes", 8'(n_written - n0), 8'h03);
    mem(spi_fram_pkg::write_mem_cmd, 16'h0000, 1, '{8'h5A, 8'h00, 8'h00}, 1'b0);
    mem(spi_fram_pkg::read_mem_cmd, 16'h07FF, 3, '{8'hA1, 8'hB2, 8'hC3}, 1'b1);
    rx_ready <= 1'b0;
    send(spi_fram_pkg::read_status_cmd, 1'b0);
    send(8'h00, 1'b0);
    repeat (200) @(posedge clk_sys_in);
    chk("stall", {7'h00, tx_ready}, 8'h00);
    chk("busy", {7'h00, busy}, 8'h01);
    rx_ready <= 1'b1;
    recv(r);
    recv(r);
    chk("stalled status", r, 8'h8C);
    xfer(8'h00, 1'b1, r);
    repeat (10) @(posedge clk_sys_in);
    chk("busy end", {7'h00, busy}, 8'h00);
    conclude();
  end
endmodule : test_spi_fram_slave_interface
`default_nettype wire
